/* File: rtl/utxs_pkg.sv */
// Shared constants and types for the transmit endpoint status block.
package utxs_pkg;

  // ----------------------------------------------------------------
  // FIFO geometry
  // ----------------------------------------------------------------
  localparam int          AW         = 6;
  localparam logic [6:0]  FIFO_DEPTH = 7'h40;
  localparam logic [4:0]  FREE_MAX   = 5'h1F;

  // ----------------------------------------------------------------
  // Register indexes; the byte address is four times the low ten bits of the index
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_TX_STATUS  = 32'h5000_1874;
  localparam logic [31:0] IDX_TX_CONTROL = 32'h5000_1876;
  localparam logic [31:0] IDX_TX_DATA    = 32'h5000_1872;
  localparam logic [31:0] IDX_EP_CONFIG  = 32'h5000_1880;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h5000_1881;
  localparam logic [31:0] IDX_IRQ_MASK   = 32'h5000_1882;
  localparam logic [11:0] ADDR_TX_STATUS  = {IDX_TX_STATUS[9:0], 2'h0};
  localparam logic [11:0] ADDR_TX_CONTROL = {IDX_TX_CONTROL[9:0], 2'h0};
  localparam logic [11:0] ADDR_TX_DATA    = {IDX_TX_DATA[9:0], 2'h0};
  localparam logic [11:0] ADDR_EP_CONFIG  = {IDX_EP_CONFIG[9:0], 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[9:0], 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK[9:0], 2'h0};

  // ----------------------------------------------------------------
  // Register selects and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NONE    = 3'h0;
  localparam logic [2:0] SEL_STATUS  = 3'h1;
  localparam logic [2:0] SEL_CONTROL = 3'h2;
  localparam logic [2:0] SEL_DATA    = 3'h3;
  localparam logic [2:0] SEL_CONFIG  = 3'h4;
  localparam logic [2:0] SEL_IRQ_ST  = 3'h5;
  localparam logic [2:0] SEL_IRQ_MSK = 3'h6;
  localparam int STS_URUN_BIT   = 7;
  localparam int STS_ACK_BIT    = 6;
  localparam int STS_DONE_BIT   = 5;
  localparam int CTL_BYPASS_BIT = 7;
  localparam int CTL_FLUSH_BIT  = 3;
  localparam int CTL_TOGGLE_BIT = 2;
  localparam int CTL_LAST_BIT   = 1;
  localparam int CTL_ARM_BIT    = 0;
  localparam int CFG_ISO_BIT    = 0;
  localparam int CFG_STALL_BIT  = 1;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_URUN_BIT   = 1;
  localparam int IRQ_NAK_BIT    = 2;
  localparam logic       BYPASS_RST   = 1'h0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT_HS} utxs_state_e;

  typedef struct packed {
    utxs_state_e st;
    logic        arm;
    logic        last;
    logic        toggle;
    logic        flush_pend;
    logic        bypass;
    logic        iso;
    logic        stall;
    logic        urun;
    logic        ack;
    logic        done;
    logic        frame_lsb;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic        valid;
    logic        rd_pend;
    logic        pid;
    logic        start;
    logic        eop;
    logic        stuff;
    logic        nak;
    logic        stall_hs;
    logic [31:0] prdata;
    logic        slverr;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
  } utxs_regs_s;

  // Decodes the low address bits; used for read capture and write.
  function automatic logic [2:0] utxs_decode(input logic [11:0] a);
    unique case (a)
      ADDR_TX_STATUS:  return SEL_STATUS;
      ADDR_TX_CONTROL: return SEL_CONTROL;
      ADDR_TX_DATA:    return SEL_DATA;
      ADDR_EP_CONFIG:  return SEL_CONFIG;
      ADDR_IRQ_STATUS: return SEL_IRQ_ST;
      ADDR_IRQ_MASK:   return SEL_IRQ_MSK;
      default:         return SEL_NONE;
    endcase
  endfunction

endpackage

/* File: rtl/utxs_mem_if.sv */
// Interface between the endpoint logic and its FIFO storage.
`timescale 1ns/1ps
`default_nettype none
interface utxs_mem_if;
  logic                   wr_en;
  logic [utxs_pkg::AW-1:0] wr_addr;
  logic [7:0]             wr_data;
  logic                   rd_en;
  logic [utxs_pkg::AW-1:0] rd_addr;
  logic [7:0]             rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output rd_data);
endinterface
`default_nettype wire

/* File: rtl/utxs_fifo_mem.sv */
// Byte storage of the transmit FIFO with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module utxs_fifo_mem (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Storage port.
  utxs_mem_if.mem  mif
);
  import utxs_pkg::*;

  logic [7:0] store_q [2**AW];

  // Read data comes from a flop so the byte output is glitch free.
  always_ff @(posedge clk_in) begin
    if (mif.wr_en) begin
      store_q[mif.wr_addr] <= mif.wr_data;
    end
    if (!rst_n_in) begin
      mif.rd_data <= 8'h00;
    end else if (mif.rd_en) begin
      mif.rd_data <= store_q[mif.rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/utxs_top.sv */
// Transmit endpoint status, arming and isochronous frame lock.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Empty FIFO mid-packet without last byte sets underrun and forces stuff error.
// - Reading the transmit status register clears the underrun flag.
// - Non-isochronous: handshake flag set on host ACK, cleared otherwise.
// - Isochronous: flag set when sent in frame; else cleared, FIFO flushed, done.
// - Handshake flag is valid with done set; status read clears it.
// - Done set on packet complete, STALL to IN, or isochronous send/discard.
// - Reading the transmit status register clears the done flag.
// - Free byte count in bits 4:0, saturating at 31, resets to 31.
// - Frame lock bypass only matters on an isochronous endpoint.
// - Bypass set: isochronous data goes out on the next IN token.
// - Bypass clear: isochronous send only when frame LSB equals toggle.
// - Frame lock bypass is zero after reset.
// - Isochronous endpoint never answers NAK when not ready.
// - Toggle and frame number bit 0 gate isochronous transmit enable.
// - Hardware clears arm after one packet or STALL; firmware re-arms.
module utxs_top (
  // Clock and reset.
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  // APB slave.
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [31:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Token side of the protocol engine.
  input  wire logic        IN_TOKEN_IN,
  input  wire logic        SOF_IN,
  input  wire logic        FRAME_LSB_IN,
  input  wire logic        HOST_ACK_IN,
  input  wire logic        HOST_TIMEOUT_IN,
  // Byte stream to the serialiser.
  input  wire logic        TX_READY_IN,
  output logic      [7:0]  TX_DATA_OUT,
  output logic             TX_VALID_OUT,
  output logic             TX_PID_DATA1_OUT,
  output logic             TX_START_OUT,
  output logic             TX_EOP_OUT,
  output logic             TX_STUFF_ERR_OUT,
  output logic             NAK_OUT,
  output logic             STALL_OUT,
  // Interrupt.
  output logic             IRQ_OUT
);
  import utxs_pkg::*;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  localparam utxs_regs_s RST_STATE = '{st: ST_IDLE, bypass: BYPASS_RST,
                                        irq_mask: IRQ_MASK_RST,
                                        default: '0};

  utxs_regs_s  s_q;
  utxs_regs_s  s_d;
  utxs_mem_if  mif ();
  logic [2:0]  sel;
  logic        setup;
  logic        access;
  logic [AW:0] used;
  logic        empty;
  logic        full;
  logic        gate;
  logic        discard;
  logic        underrun;
  logic        evt_done;
  logic        evt_nak;
  logic [4:0]  free_cnt;

  utxs_fifo_mem i_utxs_fifo_mem (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .mif      (mif)
  );

  // Free space clipped to the five-bit field.
  function automatic logic [4:0] sat_free(input logic [AW:0] u);
    logic [AW:0] fr;
    fr = FIFO_DEPTH - u;
    return (fr > {2'h0, FREE_MAX}) ? FREE_MAX : fr[4:0];
  endfunction

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  // Pointers carry one extra bit so full and empty stay distinct.
  assign sel      = utxs_decode(PADDR_IN[11:0]);
  assign setup    = PSEL_IN && !PENABLE_IN;
  assign access   = PSEL_IN && PENABLE_IN;
  assign used     = s_q.wp - s_q.rp;
  assign empty    = (used == 7'h00);
  assign full     = (used == FIFO_DEPTH);
  assign free_cnt = sat_free(used);
  // Only an isochronous endpoint is locked to the frame parity.
  assign gate     = !s_q.iso || s_q.bypass ||
                    (s_q.frame_lsb == s_q.toggle);
  // An armed frame that passed without an IN token is thrown away.
  assign discard  = (s_q.st == ST_IDLE) && !IN_TOKEN_IN && SOF_IN &&
                    s_q.iso && s_q.arm && !s_q.bypass &&
                    (s_q.frame_lsb == s_q.toggle);
  assign underrun = (s_q.st == ST_SEND) && !s_q.valid && !s_q.rd_pend &&
                    empty && !s_q.last && TX_READY_IN;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register writes and read-clears come first; hardware events are
  // applied afterwards so that a hardware event always beats a register access.
  always_comb begin
    s_d          = s_q;
    s_d.start    = 1'h0;
    s_d.eop      = 1'h0;
    s_d.stuff    = 1'h0;
    s_d.nak      = 1'h0;
    s_d.stall_hs = 1'h0;
    evt_done     = 1'h0;
    evt_nak      = 1'h0;
    mif.wr_en    = 1'h0;
    mif.wr_addr  = s_q.wp[AW-1:0];
    mif.wr_data  = PWDATA_IN[7:0];
    mif.rd_en    = 1'h0;
    mif.rd_addr  = s_q.rp[AW-1:0];

    // Read data is captured in the setup cycle and shown in access.
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      s_d.slverr = 1'h0;
      unique case (sel)
        SEL_STATUS:  s_d.prdata[7:0] = {s_q.urun, s_q.ack, s_q.done,
                                        free_cnt};
        SEL_CONTROL: s_d.prdata[7:0] = {s_q.bypass, 3'h0, s_q.flush_pend,
                                        s_q.toggle, s_q.last, s_q.arm};
        SEL_DATA:    s_d.prdata = 32'h0000_0000;
        SEL_CONFIG:  s_d.prdata[1:0] = {s_q.stall, s_q.iso};
        SEL_IRQ_ST:  s_d.prdata[2:0] = s_q.irq_st;
        SEL_IRQ_MSK: s_d.prdata[2:0] = s_q.irq_mask;
        SEL_NONE:    s_d.slverr = 1'h1;
      endcase
    end

    // Reads clear only the bits that were actually returned.
    if (access && !PWRITE_IN) begin
      if (sel == SEL_STATUS) begin
        s_d.urun = s_q.urun & ~s_q.prdata[STS_URUN_BIT];
        s_d.ack  = s_q.ack  & ~s_q.prdata[STS_ACK_BIT];
        s_d.done = s_q.done & ~s_q.prdata[STS_DONE_BIT];
      end
      if (sel == SEL_IRQ_ST) begin
        s_d.irq_st = s_q.irq_st & ~s_q.prdata[2:0];
      end
    end

    // Register writes take effect on the access edge.
    if (access && PWRITE_IN) begin
      unique case (sel)
        SEL_CONTROL: begin
          s_d.bypass = PWDATA_IN[CTL_BYPASS_BIT];
          s_d.toggle = PWDATA_IN[CTL_TOGGLE_BIT];
          s_d.last   = PWDATA_IN[CTL_LAST_BIT];
          s_d.arm    = PWDATA_IN[CTL_ARM_BIT];
          s_d.flush_pend = s_q.flush_pend | PWDATA_IN[CTL_FLUSH_BIT];
        end
        SEL_DATA: begin
          // A byte written to a full FIFO is dropped.
          if (!full) begin
            mif.wr_en = 1'h1;
            s_d.wp    = s_q.wp + 7'h01;
          end
        end
        SEL_CONFIG: begin
          s_d.iso   = PWDATA_IN[CFG_ISO_BIT];
          s_d.stall = PWDATA_IN[CFG_STALL_BIT];
        end
        SEL_IRQ_MSK: s_d.irq_mask = PWDATA_IN[2:0];
        SEL_STATUS, SEL_IRQ_ST, SEL_NONE: s_d.slverr = s_q.slverr;
      endcase
    end

    // The frame parity is taken at each start of frame.
    if (SOF_IN) begin
      s_d.frame_lsb = FRAME_LSB_IN;
    end

    // A flush waits until no packet is using the FIFO.
    if (s_q.flush_pend && s_q.st == ST_IDLE) begin
      s_d.rp         = s_q.wp;
      s_d.flush_pend = 1'h0;
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (IN_TOKEN_IN) begin
          if (s_q.stall) begin
            s_d.stall_hs = 1'h1;
            s_d.arm      = 1'h0;
            evt_done     = 1'h1;
          end else if (s_q.arm && gate) begin
            s_d.st    = ST_SEND;
            s_d.start = 1'h1;
            s_d.pid   = s_q.iso ? 1'h0 : s_q.toggle;
          end else if (!s_q.iso) begin
            s_d.nak = 1'h1;
            evt_nak = 1'h1;
          end
        end else if (discard) begin
          s_d.rp   = s_q.wp;
          s_d.ack  = 1'h0;
          s_d.arm  = 1'h0;
          s_d.last = 1'h0;
          evt_done = 1'h1;
        end
      end
      ST_SEND: begin
        if (s_q.rd_pend) begin
          s_d.rd_pend = 1'h0;
          s_d.valid   = 1'h1;
        end else if (s_q.valid) begin
          if (TX_READY_IN) begin
            s_d.valid = 1'h0;
          end
        end else if (!empty) begin
          mif.rd_en   = 1'h1;
          s_d.rp      = s_q.rp + 7'h01;
          s_d.rd_pend = 1'h1;
        end else if (s_q.last) begin
          // Payload finished; the serialiser appends CRC and EOP.
          s_d.eop  = 1'h1;
          s_d.last = 1'h0;
          if (s_q.iso) begin
            s_d.st   = ST_IDLE;
            s_d.arm  = 1'h0;
            s_d.ack  = 1'h1;
            evt_done = 1'h1;
          end else begin
            s_d.st = ST_WAIT_HS;
          end
        end else if (underrun) begin
          s_d.st    = ST_IDLE;
          s_d.stuff = 1'h1;
          s_d.arm   = 1'h0;
        end
      end
      ST_WAIT_HS: begin
        if (HOST_ACK_IN || HOST_TIMEOUT_IN) begin
          s_d.st   = ST_IDLE;
          s_d.ack  = HOST_ACK_IN;
          s_d.arm  = 1'h0;
          evt_done = 1'h1;
        end
      end
    endcase

    // Hardware sets last, so an event in a read cycle is kept.
    if (underrun) begin
      s_d.urun = 1'h1;
    end
    if (evt_done) begin
      s_d.done = 1'h1;
    end
    s_d.irq_st[IRQ_DONE_BIT] = s_d.irq_st[IRQ_DONE_BIT] | evt_done;
    s_d.irq_st[IRQ_URUN_BIT] = s_d.irq_st[IRQ_URUN_BIT] | underrun;
    s_d.irq_st[IRQ_NAK_BIT]  = s_d.irq_st[IRQ_NAK_BIT] | evt_nak;
  end

  // Synchronous reset puts every control bit at its documented value.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The slave never inserts wait states.
  assign PREADY_OUT       = 1'h1;
  assign PRDATA_OUT       = s_q.prdata;
  assign PSLVERR_OUT      = s_q.slverr;
  assign TX_DATA_OUT      = mif.rd_data;
  assign TX_VALID_OUT     = s_q.valid;
  assign TX_PID_DATA1_OUT = s_q.pid;
  assign TX_START_OUT     = s_q.start;
  assign TX_EOP_OUT       = s_q.eop;
  assign TX_STUFF_ERR_OUT = s_q.stuff;
  assign NAK_OUT          = s_q.nak;
  assign STALL_OUT        = s_q.stall_hs;
  assign IRQ_OUT          = |(s_q.irq_st & s_q.irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  underrun_flag_a: assert property (underrun |=> s_q.urun &&
    TX_STUFF_ERR_OUT && s_q.st == ST_IDLE)
    else $error("underrun did not set flag and stuff error");
  urun_clear_a: assert property (access && !PWRITE_IN &&
    sel == SEL_STATUS && s_q.prdata[STS_URUN_BIT] && !underrun
    |=> !s_q.urun)
    else $error("status read did not clear underrun");
  ack_set_a: assert property (s_q.st == ST_WAIT_HS &&
    HOST_ACK_IN |=> s_q.ack && s_q.done)
    else $error("host ACK not reported");
  iso_discard_a: assert property (discard |=> !s_q.ack &&
    s_q.done && !s_q.arm && s_q.wp == s_q.rp)
    else $error("missed isochronous frame not discarded");
  ack_clear_a: assert property (access && !PWRITE_IN &&
    sel == SEL_STATUS && s_q.prdata[STS_ACK_BIT] &&
    s_q.st != ST_WAIT_HS && !(s_q.st == ST_SEND && s_q.iso)
    |=> !s_q.ack)
    else $error("status read did not clear handshake flag");
  stall_done_a: assert property (s_q.st == ST_IDLE &&
    IN_TOKEN_IN && s_q.stall |=> STALL_OUT && s_q.done && !s_q.arm)
    else $error("STALL answer did not finish the endpoint");
  done_hold_a: assert property (evt_done |=> s_q.done)
    else $error("done event lost in read-clear cycle");
  free_full_a: assert property (empty |-> free_cnt == FREE_MAX)
    else $error("free count wrong with empty FIFO");
  free_drop_a: assert property (used == 7'h30 |->
    free_cnt == 5'h10)
    else $error("free count not depth minus fill");
  non_iso_go_a: assert property (s_q.st == ST_IDLE &&
    IN_TOKEN_IN && !s_q.stall && s_q.arm && !s_q.iso
    |=> TX_START_OUT && s_q.st == ST_SEND)
    else $error("armed endpoint did not start");
  bypass_go_a: assert property (s_q.st == ST_IDLE &&
    IN_TOKEN_IN && !s_q.stall && s_q.arm && s_q.iso && s_q.bypass
    |=> TX_START_OUT && !TX_PID_DATA1_OUT)
    else $error("bypass did not send on next IN");
  frame_lock_a: assert property (s_q.st == ST_IDLE &&
    IN_TOKEN_IN && s_q.iso && !s_q.bypass &&
    s_q.frame_lsb != s_q.toggle |=> !TX_START_OUT && !NAK_OUT)
    else $error("isochronous send outside its frame");
  bypass_rst_a: assert property ($rose(RST_N_IN) |->
    !s_q.bypass)
    else $error("bypass set after reset");
  arm_clear_a: assert property (s_q.st == ST_WAIT_HS &&
    HOST_TIMEOUT_IN |=> !s_q.arm && !s_q.ack && s_q.done)
    else $error("arm not cleared after packet");

  nak_cov_c: cover property (NAK_OUT);
  iso_sent_c: cover property (TX_START_OUT && s_q.iso ##[1:200]
    TX_EOP_OUT);
  underrun_c: cover property (TX_STUFF_ERR_OUT);
  discard_c: cover property (discard);
endmodule
`default_nettype wire

/* File: verif/utxs_host_model.sv */
// Host and serialiser model facing the token and byte ports.
`timescale 1ns/1ps
`default_nettype none
module utxs_host_model (
  // Clock.
  input  wire logic       clk_in,
  // From the endpoint.
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_start_in,
  input  wire logic       tx_eop_in,
  input  wire logic       tx_stuff_in,
  input  wire logic       nak_in,
  input  wire logic       stall_in,
  // To the endpoint.
  output logic            in_token_out,
  output logic            sof_out,
  output logic            frame_lsb_out,
  output logic            ack_out,
  output logic            timeout_out,
  output logic            ready_out
);
  int unsigned n_start = 0;
  int unsigned n_stall = 0;
  logic [7:0]  last_byte = 8'h00;
  int unsigned n_eop   = 0;
  int unsigned n_stuff = 0;
  int unsigned n_nak   = 0;
  int unsigned n_bytes = 0;
  logic        reply_ack = 1'b1;
  logic        iso_mode  = 1'b0;
  logic [1:0]  ph        = 2'h0;
  // All lines idle at time zero.
  initial begin
    in_token_out  = 1'b0;
    sof_out       = 1'b0;
    frame_lsb_out = 1'b0;
    ack_out       = 1'b0;
    timeout_out   = 1'b0;
    ready_out     = 1'b0;
  end
  // One IN token pulse.
  task automatic in_token();
    @(posedge clk_in);
    in_token_out <= 1'b1;
    @(posedge clk_in);
    in_token_out <= 1'b0;
  endtask
  // Start of frame with the new frame number bit.
  task automatic sof(input logic lsb);
    @(posedge clk_in);
    sof_out       <= 1'b1;
    frame_lsb_out <= lsb;
    @(posedge clk_in);
    sof_out <= 1'b0;
  endtask
  // The serialiser stalls one cycle in four, so bytes must wait.
  // The host answers a finished packet only when it is not iso.
  always @(posedge clk_in) begin
    ph          <= ph + 2'h1;
    ready_out   <= (ph != 2'h3);
    ack_out     <= tx_eop_in && !iso_mode && reply_ack;
    timeout_out <= tx_eop_in && !iso_mode && !reply_ack;
    n_start     <= n_start + int'(tx_start_in);
    n_eop       <= n_eop + int'(tx_eop_in);
    n_stuff     <= n_stuff + int'(tx_stuff_in);
    n_nak       <= n_nak + int'(nak_in);
    n_stall     <= n_stall + int'(stall_in);
    last_byte   <= (tx_valid_in && ready_out) ? tx_data_in : last_byte;
    n_bytes     <= n_bytes + int'(tx_valid_in && ready_out);
  end
endmodule
`default_nettype wire

/* File: verif/utxs_tb_top.sv */
// Self-checking bench for the transmit endpoint status block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module utxs_tb_top;
  import utxs_pkg::*;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [31:0] paddr  = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic        pready, pslverr, slv, irq, tok, sof, flsb, hack, htmo;
  logic        rdy, vld, start, eop, stuff, nak, pid, stl;
  logic [7:0]  txd;
  int unsigned mismatches  = 0;
  int unsigned comparisons = 0;
  int unsigned b;
  int unsigned c;
  utxs_top i_utxs_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .IN_TOKEN_IN(tok), .SOF_IN(sof), .FRAME_LSB_IN(flsb), .HOST_ACK_IN(hack),
    .HOST_TIMEOUT_IN(htmo), .TX_READY_IN(rdy), .TX_DATA_OUT(txd),
    .TX_VALID_OUT(vld), .TX_PID_DATA1_OUT(pid), .TX_START_OUT(start),
    .TX_EOP_OUT(eop), .TX_STUFF_ERR_OUT(stuff), .NAK_OUT(nak), .STALL_OUT(stl),
    .IRQ_OUT(irq));
  utxs_host_model i_utxs_host_model (.clk_in(clk), .tx_valid_in(vld),
    .tx_start_in(start), .tx_eop_in(eop), .tx_stuff_in(stuff),
    .tx_data_in(txd), .nak_in(nak), .stall_in(stl),
    .in_token_out(tok), .sof_out(sof), .frame_lsb_out(flsb),
    .ack_out(hack), .timeout_out(htmo), .ready_out(rdy));
  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= {20'h00000, a};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv  = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Sends IN and waits boundedly for the packet to end, plus handshake.
  task automatic serve_in();
    int unsigned e;
    e = i_utxs_host_model.n_eop + i_utxs_host_model.n_stuff;
    i_utxs_host_model.in_token();
    for (int i = 0; i < 300; i++) begin
      if (i_utxs_host_model.n_eop + i_utxs_host_model.n_stuff != e) break;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_TX_STATUS);
    `CHK("status", 32'h1F, rv)
    rd(ADDR_TX_CONTROL);
    `CHK("bypass", 1'b0, rv[7])
    rd(12'h3FC);
    `CHK("unmapped err", 1'b1, slv)
    $display("test reset finished");
  endtask
  // The free count saturates while more than 31 bytes are free.
  task automatic t_free();
    for (int i = 0; i < 48; i++) begin
      wr(ADDR_TX_DATA, 32'(i));
      if (i == 32) begin
        rd(ADDR_TX_STATUS);
        `CHK("free 33", 32'h1F, rv)
      end
      if (i == 33) begin
        rd(ADDR_TX_STATUS);
        `CHK("free 34", 32'h1E, rv)
      end
    end
    rd(ADDR_TX_STATUS);
    `CHK("free 48", 32'h10, rv)
    wr(ADDR_TX_CONTROL, 32'h8);
    rd(ADDR_TX_STATUS);
    `CHK("flushed", 32'h1F, rv)
    $display("test free count finished");
  endtask
  task automatic t_ack(input logic ack, input logic m, input logic [31:0] x);
    b = i_utxs_host_model.n_bytes;
    i_utxs_host_model.reply_ack = ack;
    wr(ADDR_IRQ_MASK, {31'h0, m});
    repeat (3) wr(ADDR_TX_DATA, 32'h5A);
    wr(ADDR_TX_CONTROL, 32'h3);
    serve_in();
    `CHK("bytes", b + 3, i_utxs_host_model.n_bytes)
    `CHK("irq", m, irq)
    rd(ADDR_TX_CONTROL);
    `CHK("arm", 1'b0, rv[0])
    rd(ADDR_TX_STATUS);
    `CHK("status", x, rv)
    rd(ADDR_TX_STATUS);
    `CHK("reread", 32'h1F, rv)
    rd(ADDR_IRQ_STATUS);
    `CHK("irq status", 32'h1, rv)
    @(posedge clk);
    #1;
    `CHK("irq clear", 1'b0, irq)
    $display("test handshake finished");
  endtask
  task automatic t_urun();
    b = i_utxs_host_model.n_stuff;
    wr(ADDR_TX_DATA, 32'hC3);
    wr(ADDR_TX_CONTROL, 32'h5);
    serve_in();
    `CHK("stuff", b + 1, i_utxs_host_model.n_stuff)
    `CHK("byte", 8'hC3, i_utxs_host_model.last_byte)
    `CHK("pid", 1'b1, pid)
    rd(ADDR_TX_STATUS);
    `CHK("underrun", 32'h9F, rv)
    rd(ADDR_TX_STATUS);
    `CHK("underrun clr", 32'h1F, rv)
    $display("test underrun finished");
  endtask
  task automatic t_iso();
    i_utxs_host_model.iso_mode = 1'b1;
    wr(ADDR_EP_CONFIG, 32'h1);
    wr(ADDR_TX_DATA, 32'h11);
    wr(ADDR_TX_CONTROL, 32'h83);
    i_utxs_host_model.sof(1'b1);
    b = i_utxs_host_model.n_start;
    serve_in();
    `CHK("bypass send", b + 1, i_utxs_host_model.n_start)
    rd(ADDR_TX_STATUS);
    `CHK("iso sent", 32'h7F, rv)
    wr(ADDR_TX_DATA, 32'h22);
    wr(ADDR_TX_CONTROL, 32'h3);
    i_utxs_host_model.sof(1'b1);
    c = i_utxs_host_model.n_nak;
    serve_in();
    `CHK("no nak", c, i_utxs_host_model.n_nak)
    `CHK("locked", b + 1, i_utxs_host_model.n_start)
    i_utxs_host_model.sof(1'b0);
    serve_in();
    `CHK("lsb match", b + 2, i_utxs_host_model.n_start)
    rd(ADDR_TX_STATUS);
    `CHK("iso done", 32'h7F, rv)
    wr(ADDR_TX_DATA, 32'h33);
    wr(ADDR_TX_CONTROL, 32'h3);
    i_utxs_host_model.sof(1'b0);
    i_utxs_host_model.sof(1'b0);
    rd(ADDR_TX_STATUS);
    `CHK("discard", 32'h3F, rv)
    $display("test iso finished");
  endtask
  // Unarmed IN earns a NAK; with stall set, IN earns STALL and done.
  task automatic t_stall();
    i_utxs_host_model.iso_mode = 1'b0;
    wr(ADDR_EP_CONFIG, 32'h0);
    b = i_utxs_host_model.n_nak;
    serve_in();
    `CHK("nak", b + 1, i_utxs_host_model.n_nak)
    wr(ADDR_EP_CONFIG, 32'h2);
    wr(ADDR_TX_CONTROL, 32'h1);
    b = i_utxs_host_model.n_stall;
    serve_in();
    `CHK("stall", b + 1, i_utxs_host_model.n_stall)
    rd(ADDR_TX_CONTROL);
    `CHK("stall arm", 1'b0, rv[0])
    rd(ADDR_TX_STATUS);
    `CHK("stall done", 32'h3F, rv)
    $display("test stall finished");
  endtask
  // ----------------------------------------------------------------
  // Clock, run, verdict
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  // Reset is held, then each scenario runs in turn; the handshake scenario runs twice.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_free();
    t_ack(1'b1, 1'b1, 32'h7F);
    t_ack(1'b0, 1'b0, 32'h3F);
    t_urun();
    t_iso();
    t_stall();
    wrap_up();
  end
  // Whole run is under two thousand cycles; this cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
